/* File: tdmc_pkg.sv */
/*
 * tdmc_pkg: constants and types for the cartridge and developer motor block.
 * assumes a 125 MHz system clock and a reference clock well below it.
 */
package tdmc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int TDMC_CLK_PERIOD_NS = 8;
	localparam int TDMC_CNT_W = 20;
	// tolerance band numerator and denominator: 6.25 percent = 1/16
	localparam int TDMC_TOL_SHIFT = 4;
	// commutation step time per tach period: six steps per period
	localparam int TDMC_STEPS = 6;
	localparam logic [TDMC_CNT_W-1:0] TDMC_CNT_RST = 20'h00000;
	localparam logic [TDMC_CNT_W-1:0] TDMC_STEP_INIT = 20'h00800;
	localparam logic [TDMC_CNT_W-1:0] TDMC_STEP_MIN = 20'h00010;
	localparam logic [TDMC_CNT_W-1:0] TDMC_CNT_MAX = 20'hFFFFF;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] TDMC_REG_CTRL = 4'h0;
	localparam logic [3:0] TDMC_REG_STAT = 4'h1;
	localparam logic [3:0] TDMC_REG_IRQ = 4'h2;
	localparam logic [3:0] TDMC_REG_MASK = 4'h3;
	localparam logic [3:0] TDMC_REG_REFP = 4'h4;
	localparam logic [3:0] TDMC_REG_TACHP = 4'h5;
	localparam int TDMC_IRQ_LOCK = 0;
	localparam int TDMC_IRQ_UNLOCK = 1;
	localparam int TDMC_IRQ_BRAKE = 2;
	localparam int TDMC_IRQ_HALL = 3;
	localparam logic [3:0] TDMC_IRQ_RST = 4'h0;
	localparam logic [3:0] TDMC_MASK_RST = 4'h0;

	// ----------------------------------------------------------------
	// motor states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TDMC_CART_OFF,
		TDMC_CART_REV,
		TDMC_CART_FWD
	} tdmc_cart_t;

	typedef enum logic [1:0] {
		TDMC_DEV_STOP,
		TDMC_DEV_RUN,
		TDMC_DEV_BRAKE
	} tdmc_dev_t;

	// bridge code per hall state (A,B,C); 6'h00 is all windings floating
	function automatic logic [5:0] tdmc_excite(input logic [2:0] hall);
		case (hall)
			3'h5: tdmc_excite = 6'h09;
			3'h4: tdmc_excite = 6'h21;
			3'h6: tdmc_excite = 6'h24;
			3'h2: tdmc_excite = 6'h06;
			3'h3: tdmc_excite = 6'h12;
			3'h1: tdmc_excite = 6'h18;
			default: tdmc_excite = 6'h00;
		endcase
	endfunction

endpackage

/* File: tdmc_sync.sv */
/*
 * tdmc_sync: two flip-flop synchroniser with rising-edge pulse.
 * assumes the input is a level from outside the clock domain.
 */
`timescale 1ns/10ps
module tdmc_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out,
	output logic [W-1:0] rise
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// ----------------------------------------------------------------
	// synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign sync_out = sync_q;
	assign rise = sync_q & ~prev_q;

endmodule

/* File: tdmc_top.sv */
/*
 * tdmc_top: cartridge dc motor control and developer brushless motor driver.
 * assumes pins are asynchronous and the register port is on clock.
 */
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// Functional notes
// - the cartridge motor runs only while its enable input is high.
// - enabled with direction low, the cartridge motor turns in reverse.
// - enabled with direction high, the cartridge motor turns forward.
// - developer motor rotates while run_n is low and stops when high.
// - brake_n low actively brakes the developer motor.
// - the three hall sensors select the winding excitation in sequence.
// - tach is compared to the reference clock and commutation timing moves.
// - lock when tach period is within 6.25 percent of the reference period.
module tdmc_top
	import tdmc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cart_motor_enable,
	input wire logic cart_motor_direction,
	input wire logic dev_motor_run_n,
	input wire logic dev_motor_brake_n,
	input wire logic dev_motor_ref_clock,
	input wire logic tach_pulse,
	input wire logic [2:0] hall_abc,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic cart_motor_fwd,
	output logic cart_motor_rev,
	output logic [5:0] dev_phase_drive,
	output logic dev_brake_drive,
	output logic lock_led,
	output logic irq
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// active-low pins enter inverted so a flushed synchroniser reads idle
	logic [8:0] pins_raw;
	logic [8:0] pins_s;
	logic [8:0] pins_rise;

	assign pins_raw = {cart_motor_enable, cart_motor_direction,
		~dev_motor_run_n, ~dev_motor_brake_n, dev_motor_ref_clock,
		tach_pulse, hall_abc};

	tdmc_sync #(.W(9)) u_sync (
		.clock(clock),
		.rst(rst),
		.async_in(pins_raw),
		.sync_out(pins_s),
		.rise(pins_rise)
	);

	wire en_s = pins_s[8];
	wire dir_s = pins_s[7];
	wire run_n_s = !pins_s[6];
	wire brake_n_s = !pins_s[5];
	wire ref_rise = pins_rise[4];
	wire tach_rise = pins_rise[3];
	wire [2:0] hall_s = pins_s[2:0];

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// bit0 forces both motors off, bit1 enables commutation advance
	logic [1:0] ctrl_q;
	wire wr_ctrl = reg_write && (reg_addr == TDMC_REG_CTRL);
	wire wr_irq = reg_write && (reg_addr == TDMC_REG_IRQ);
	wire wr_mask = reg_write && (reg_addr == TDMC_REG_MASK);
	wire inhibit = ctrl_q[0];
	wire adv_en = ctrl_q[1];

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= 2'h2;
		end else if (wr_ctrl) begin
			ctrl_q <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// cartridge motor
	// ----------------------------------------------------------------
	tdmc_cart_t cart_d;
	tdmc_cart_t cart_q;

	always_comb begin
		if (!en_s || inhibit) begin
			cart_d = TDMC_CART_OFF;
		end else if (dir_s) begin
			cart_d = TDMC_CART_FWD;
		end else begin
			cart_d = TDMC_CART_REV;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cart_q <= TDMC_CART_OFF;
			cart_motor_fwd <= 1'b0;
			cart_motor_rev <= 1'b0;
		end else begin
			cart_q <= cart_d;
			cart_motor_fwd <= (cart_d == TDMC_CART_FWD);
			cart_motor_rev <= (cart_d == TDMC_CART_REV);
		end
	end

	// ----------------------------------------------------------------
	// developer motor state
	// ----------------------------------------------------------------
	tdmc_dev_t dev_d;
	tdmc_dev_t dev_q;

	always_comb begin
		case (dev_q)
			TDMC_DEV_STOP: begin
				if (!brake_n_s) begin
					dev_d = TDMC_DEV_BRAKE;
				end else if (!run_n_s && !inhibit) begin
					dev_d = TDMC_DEV_RUN;
				end else begin
					dev_d = TDMC_DEV_STOP;
				end
			end
			TDMC_DEV_RUN: begin
				if (!brake_n_s) begin
					dev_d = TDMC_DEV_BRAKE;
				end else if (run_n_s || inhibit) begin
					dev_d = TDMC_DEV_STOP;
				end else begin
					dev_d = TDMC_DEV_RUN;
				end
			end
			TDMC_DEV_BRAKE: begin
				if (brake_n_s) begin
					dev_d = TDMC_DEV_STOP;
				end else begin
					dev_d = TDMC_DEV_BRAKE;
				end
			end
			default: dev_d = TDMC_DEV_STOP;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dev_q <= TDMC_DEV_STOP;
		end else begin
			dev_q <= dev_d;
		end
	end

	wire running = (dev_q == TDMC_DEV_RUN);
	wire brake_on = (dev_q == TDMC_DEV_BRAKE);

	// ----------------------------------------------------------------
	// period measurement
	// ----------------------------------------------------------------
	logic [TDMC_CNT_W-1:0] ref_cnt_q;
	logic [TDMC_CNT_W-1:0] ref_per_q;
	logic [TDMC_CNT_W-1:0] tach_cnt_q;
	logic [TDMC_CNT_W-1:0] tach_per_q;
	logic tach_valid_q;

	function automatic logic [TDMC_CNT_W-1:0] tdmc_inc(
		input logic [TDMC_CNT_W-1:0] v);
		tdmc_inc = (v == TDMC_CNT_MAX) ? v : v + 20'h00001;
	endfunction

	always_ff @(posedge clock) begin
		if (rst) begin
			ref_cnt_q <= TDMC_CNT_RST;
			ref_per_q <= TDMC_CNT_RST;
		end else if (ref_rise) begin
			ref_cnt_q <= TDMC_CNT_RST;
			ref_per_q <= tdmc_inc(ref_cnt_q);
		end else begin
			ref_cnt_q <= tdmc_inc(ref_cnt_q);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tach_cnt_q <= TDMC_CNT_RST;
			tach_per_q <= TDMC_CNT_RST;
			tach_valid_q <= 1'b0;
		end else if (tach_rise) begin
			tach_cnt_q <= TDMC_CNT_RST;
			tach_per_q <= tdmc_inc(tach_cnt_q);
			tach_valid_q <= running;
		end else begin
			tach_cnt_q <= tdmc_inc(tach_cnt_q);
			tach_valid_q <= tach_valid_q && running;
		end
	end

	// ----------------------------------------------------------------
	// lock detection
	// ----------------------------------------------------------------
	wire [TDMC_CNT_W-1:0] tol = ref_per_q >> TDMC_TOL_SHIFT;
	wire [TDMC_CNT_W:0] band_hi = {1'b0, ref_per_q} + {1'b0, tol};
	wire [TDMC_CNT_W:0] band_lo = {1'b0, ref_per_q} - {1'b0, tol};
	wire [TDMC_CNT_W:0] new_per = {1'b0, tdmc_inc(tach_cnt_q)};
	wire in_band = (new_per >= band_lo) && (new_per <= band_hi)
		&& (ref_per_q != TDMC_CNT_RST);
	logic lock_q;
	// one judgement per measured tach period
	wire judge = tach_rise && tach_valid_q;
	wire lock_d = !running ? 1'b0 :
		judge ? in_band : lock_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			lock_q <= 1'b0;
			lock_led <= 1'b0;
		end else begin
			lock_q <= lock_d;
			lock_led <= lock_d;
		end
	end

	// ----------------------------------------------------------------
	// speed loop: commutation delay trimmed by period error
	// ----------------------------------------------------------------
	logic [TDMC_CNT_W-1:0] step_q;
	logic [TDMC_CNT_W-1:0] wait_q;
	logic [2:0] hall_q;
	logic [5:0] drive_q;
	wire fast = tach_per_q < ref_per_q;
	wire [TDMC_CNT_W-1:0] trim = step_q >> TDMC_TOL_SHIFT;
	wire [TDMC_CNT_W-1:0] step_up = (step_q > TDMC_CNT_MAX - trim) ?
		TDMC_CNT_MAX : step_q + trim;
	wire [TDMC_CNT_W-1:0] step_dn = (step_q < TDMC_STEP_MIN + trim) ?
		TDMC_STEP_MIN : step_q - trim;
	wire hall_change = (hall_s != hall_q);

	always_ff @(posedge clock) begin
		if (rst) begin
			step_q <= TDMC_STEP_INIT;
		end else if (!running) begin
			step_q <= TDMC_STEP_INIT;
		end else if (judge && adv_en) begin
			step_q <= fast ? step_up : step_dn;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hall_q <= 3'h0;
			wait_q <= TDMC_CNT_RST;
			drive_q <= 6'h00;
		end else if (!running) begin
			hall_q <= hall_s;
			wait_q <= TDMC_CNT_RST;
			drive_q <= 6'h00;
		end else if (hall_change) begin
			hall_q <= hall_s;
			wait_q <= adv_en ? step_q : TDMC_CNT_RST;
		end else if (wait_q != TDMC_CNT_RST) begin
			wait_q <= wait_q - 20'h00001;
		end else begin
			drive_q <= tdmc_excite(hall_q);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dev_phase_drive <= 6'h00;
			dev_brake_drive <= 1'b0;
		end else begin
			dev_phase_drive <= running ? drive_q : 6'h00;
			dev_brake_drive <= brake_on;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic [3:0] irq_q;
	logic [3:0] mask_q;
	logic lock_prev_q;
	wire hall_invalid = (hall_s == 3'h0) || (hall_s == 3'h7);
	wire hall_bad = running && hall_invalid;
	wire ev_gain = !lock_prev_q && lock_q;
	wire ev_lost = lock_prev_q && !lock_q;
	wire ev_brake = (dev_d == TDMC_DEV_BRAKE) && !brake_on;
	wire [3:0] ev = {hall_bad, ev_brake, ev_lost, ev_gain};
	wire [3:0] clr = wr_irq ? reg_wdata[3:0] : 4'h0;

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_q <= TDMC_IRQ_RST;
			mask_q <= TDMC_MASK_RST;
			lock_prev_q <= 1'b0;
			irq <= 1'b0;
		end else begin
			irq_q <= (irq_q & ~clr) | ev;
			lock_prev_q <= lock_q;
			irq <= |(irq_q & mask_q);
			if (wr_mask) begin
				mask_q <= reg_wdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	wire [31:0] stat_word = {22'h000000, hall_s, lock_q, 1'b0,
		dev_q, cart_q, 1'b0};
	logic [31:0] rd_mux;

	always_comb begin
		case (reg_addr)
			TDMC_REG_CTRL: rd_mux = {30'h00000000, ctrl_q};
			TDMC_REG_STAT: rd_mux = stat_word;
			TDMC_REG_IRQ: rd_mux = {28'h0000000, irq_q};
			TDMC_REG_MASK: rd_mux = {28'h0000000, mask_q};
			TDMC_REG_REFP: rd_mux = {12'h000, ref_per_q};
			TDMC_REG_TACHP: rd_mux = {12'h000, tach_per_q};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

/* File: tdmc_top_asserts.sv */
/*
 * tdmc_top_asserts: port checks for tdmc_top, bound below.
 * assumes pins hold steady a few cycles around each change.
 */
`timescale 1ns/10ps
module tdmc_top_asserts
	import tdmc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cart_motor_enable,
	input wire logic cart_motor_direction,
	input wire logic dev_motor_run_n,
	input wire logic dev_motor_brake_n,
	input wire logic dev_motor_ref_clock,
	input wire logic tach_pulse,
	input wire logic [2:0] hall_abc,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic cart_motor_fwd,
	input wire logic cart_motor_rev,
	input wire logic [5:0] dev_phase_drive,
	input wire logic dev_brake_drive,
	input wire logic lock_led,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// pin histories
	// ----------------------------------------------------------------
	sequence s_cart_idle;
		!cart_motor_enable [*4];
	endsequence
	sequence s_cart_back;
		(cart_motor_enable && !cart_motor_direction) [*4];
	endsequence
	sequence s_cart_ahead;
		(cart_motor_enable && cart_motor_direction) [*4];
	endsequence
	sequence s_dev_idle;
		(dev_motor_run_n && dev_motor_brake_n) [*4];
	endsequence
	sequence s_braking;
		!dev_motor_brake_n [*4];
	endsequence
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_cart_off: assert property (s_cart_idle |-> !cart_motor_fwd && !cart_motor_rev)
		else $error("cartridge driven while disabled");
	a_cart_reverse: assert property (s_cart_back |-> cart_motor_rev && !cart_motor_fwd)
		else $error("cartridge not reversing");
	a_cart_forward: assert property (s_cart_ahead |-> cart_motor_fwd && !cart_motor_rev)
		else $error("cartridge not forward");
	a_dev_stopped: assert property (s_dev_idle |=> dev_phase_drive == 6'h00 && !dev_brake_drive)
		else $error("developer motor not stopped");
	a_brake_applied: assert property (s_braking |=> dev_brake_drive && dev_phase_drive == 6'h00)
		else $error("brake not applied");
	a_brake_excl: assert property (dev_brake_drive |-> dev_phase_drive == 6'h00)
		else $error("windings driven while braking");
	a_phase_pair: assert property (dev_phase_drive != 6'h00 |-> $countones(dev_phase_drive) == 2)
		else $error("bad winding code");
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_led_tach: assert property ($rose(lock_led) |-> $past(tach_pulse, 2))
		else $error("lock rose away from a tach edge");
endmodule

bind tdmc_top tdmc_top_asserts u_chk (.*);

/* File: tdmc_host_model.sv */
/*
 * tdmc_host_model: controller side driving the cartridge pins and ref clock.
 * assumes the bench asks for feeding through feed_req and rev_req.
 */
`timescale 1ns/10ps
module tdmc_host_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic feed_req,
	input wire logic rev_req,
	input wire logic toner_left,
	input wire logic cover_closed,
	output logic cart_motor_enable,
	output logic cart_motor_direction,
	output logic dev_motor_ref_clock
);
	wire logic feed_ok;
	// feed only with toner left and cover closed
	assign feed_ok = feed_req && toner_left && cover_closed;
	always_ff @(posedge clock) begin
		if (rst) begin
			cart_motor_enable <= 1'b0;
			cart_motor_direction <= 1'b0;
		end else begin
			cart_motor_enable <= feed_ok;
			cart_motor_direction <= !rev_req;
		end
	end
	// free running reference, off the system clock phase
	initial begin
		dev_motor_ref_clock = 1'b0;
		#1;
		forever #80 dev_motor_ref_clock = ~dev_motor_ref_clock;
	end
endmodule

/* File: tdmc_top_tb_top.sv */
/*
 * tdmc_top_tb_top: self-checking bench for tdmc_top.
 * assumes tdmc_host_model and the bound checker are compiled.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tdmc_top_tb_top;
	import tdmc_pkg::*;
	typedef struct {int sel; logic [31:0] v;} tdmc_note_t;
	logic clock = 1'b0, rst = 1'b1, tach_pulse = 1'b0, tach_on = 1'b0;
	logic dev_motor_run_n = 1'b1, dev_motor_brake_n = 1'b1;
	logic feed_req = 1'b0, rev_req = 1'b0, toner_left = 1'b1;
	logic cover_closed = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [2:0] hall_abc = 3'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic cart_motor_enable, cart_motor_direction, dev_motor_ref_clock;
	logic cart_motor_fwd, cart_motor_rev, dev_brake_drive, lock_led, irq;
	logic [5:0] dev_phase_drive;
	logic rd_taken = 1'b0, snap = 1'b0;
	int err_count = 0, compares = 0, tach_half = 80;
	tdmc_note_t q[$];
	string nm[5] = '{"reg_rdata", "cart", "dev", "lock_led", "irq"};
	logic [3:0] cmd[6] = '{4'hF, 4'h6, 4'hE, 4'hA, 4'hE, 4'hC};
	logic [1:0] cexp[6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};

	tdmc_host_model u_host (.*);
	tdmc_top u_dut (.*);

	always #4 clock = ~clock;
	initial begin
		#3;
		forever begin
			#(tach_half);
			if (tach_on) tach_pulse <= ~tach_pulse;
		end
	end
	// ----------------------------------------------------------------
	// observation and scoreboard
	// ----------------------------------------------------------------
	function automatic logic [31:0] obs(input int s);
		case (s)
			0: obs = reg_rdata;
			1: obs = {30'h0, cart_motor_fwd, cart_motor_rev};
			2: obs = {30'h0, dev_brake_drive, |dev_phase_drive};
			3: obs = {31'h0, lock_led};
			default: obs = {31'h0, irq};
		endcase
	endfunction
	always @(posedge clock) begin
		tdmc_note_t n;
		if (rd_taken || snap) begin
			n = q.pop_front();
			`CHK(nm[n.sel], n.v, obs(n.sel))
		end
		rd_taken <= reg_read;
	end
	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic bus(input logic w, r, input logic [3:0] a,
		input logic [31:0] d);
		reg_write <= w;
		reg_read <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] v);
		q.push_back('{0, v});
		bus(1'b0, 1'b1, a, 32'h0);
		bus(1'b0, 1'b0, a, 32'h0);
	endtask
	task automatic chk(input int s, input logic [31:0] v, input int n);
		for (int i = 0; i < n && obs(s) !== v; i++) @(posedge clock);
		q.push_back('{s, v});
		snap <= 1'b1;
		@(posedge clock);
		snap <= 1'b0;
		@(posedge clock);
	endtask
	task automatic conclude();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#200000;
		err_count++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		logic [31:0] r;
		void'($urandom(32'h220ce980));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(TDMC_REG_CTRL, 32'h2);
		rd(TDMC_REG_IRQ, 32'h0);
		rd(TDMC_REG_MASK, 32'h0);
		wr(4'hF, 32'hFFFFFFFF);
		rd(4'hF, 32'h0);
		r = $urandom & 32'hF;
		wr(TDMC_REG_MASK, r);
		rd(TDMC_REG_MASK, r);
		wr(TDMC_REG_MASK, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			{feed_req, toner_left, cover_closed, rev_req} <= cmd[i];
			@(posedge clock);
			chk(1, {30'h0, cexp[i]}, 10);
		end
		$display("test cartridge done");
		hall_abc <= 3'(1 + $urandom % 6);
		dev_motor_run_n <= 1'b0;
		tach_on <= 1'b1;
		chk(2, 32'h1, 4000);
		chk(3, 32'h1, 2000);
		rd(TDMC_REG_REFP, 32'h14);
		rd(TDMC_REG_TACHP, 32'h14);
		rd(TDMC_REG_IRQ, 32'h1);
		wr(TDMC_REG_MASK, 32'h1);
		chk(4, 32'h1, 4);
		wr(TDMC_REG_IRQ, 32'h1);
		chk(4, 32'h0, 4);
		tach_half = 100;
		chk(3, 32'h0, 200);
		rd(TDMC_REG_IRQ, 32'h2);
		hall_abc <= 3'h7;
		chk(2, 32'h0, 4000);
		rd(TDMC_REG_IRQ, 32'hA);
		hall_abc <= 3'(1 + $urandom % 6);
		chk(2, 32'h1, 4000);
		dev_motor_brake_n <= 1'b0;
		chk(2, 32'h2, 8);
		rd(TDMC_REG_IRQ, 32'hE);
		dev_motor_brake_n <= 1'b1;
		dev_motor_run_n <= 1'b1;
		chk(2, 32'h0, 8);
		$display("test developer done");
		conclude();
	end
endmodule
